// ### src/ccsw_defs.vh
// constants for the cpu clock source switcher: register map, fields, codes
// assumes inclusion by the design file and the testbench of the block
`ifndef CCSW_DEFS_VH
`define CCSW_DEFS_VH

// register byte addresses on the axi4-lite bus
`define CCSW_ADDR_SUPPLY 8'h00
`define CCSW_ADDR_MODE 8'h04
`define CCSW_ADDR_RUN 8'h08
`define CCSW_ADDR_SYSSEL 8'h0c
`define CCSW_ADDR_SUBSEL 8'h10
`define CCSW_ADDR_STSEL 8'h14
`define CCSW_ADDR_STSTAT 8'h18

// reset values
`define CCSW_RST_SUPPLY 8'h00
`define CCSW_RST_MODE 8'h00
`define CCSW_RST_RUN 8'hc0
`define CCSW_RST_SYSSEL 8'h00
`define CCSW_RST_SUBSEL 8'h00
`define CCSW_RST_STSEL 8'h07

// writable masks
`define CCSW_WM_SUPPLY 8'h90
`define CCSW_WM_MODE 8'hf7
`define CCSW_WM_RUN 8'hc3
`define CCSW_WM_SYSSEL 8'h51
`define CCSW_WM_SUBSEL 8'h01
`define CCSW_WM_STSEL 8'h07

// subclock_supply_mode fields
`define CCSW_B_LOWPWR 7
`define CCSW_B_ITSEL 4
// oscillator_mode_setup fields
`define CCSW_B_MAINEXT 7
`define CCSW_B_MAINOSC 6
`define CCSW_B_SUBEXT 5
`define CCSW_B_SUBOSC 4
`define CCSW_B_GAIN 0
// oscillator_run_control fields
`define CCSW_B_MAIN_OSC_STOP 7
`define CCSW_B_SSTOP 6
`define CCSW_B_MIDEN 1
`define CCSW_B_HSTOP 0
// system_clock_select fields
`define CCSW_B_SUBSTAT 7
`define CCSW_B_SUBSEL 6
`define CCSW_B_EXTSTAT 5
`define CCSW_B_EXTSEL 4
`define CCSW_B_MIDSTAT 1
`define CCSW_B_MIDSEL 0
// subsystem_source_select field
`define CCSW_B_LOWSEL 0

// clock source codes
`define CCSW_SRC_HIGH 3'h0
`define CCSW_SRC_MID 3'h1
`define CCSW_SRC_MAIN 3'h2
`define CCSW_SRC_SUB 3'h3
`define CCSW_SRC_LOW 3'h4

// settle counter: width, saturation, highest flag index
`define CCSW_CNT_W 19
`define CCSW_CNT_MAX 19'h40000
`define CCSW_FLAG_TOP 3'h7

// idle mclk cycles between dropping old gate and raising new gate
`define CCSW_GAP_CYC 3'h4

// axi responses
`define CCSW_RESP_OK 2'h0
`define CCSW_RESP_ERR 2'h2

`endif

// ### src/ccsw_switcher.v
// cpu clock source switcher: axi4-lite registers, oscillator run control,
// break-before-make source gating and x1 settle counter
// assumes oscillator ready and x1 clock pins are asynchronous to mclk,
// standby_req comes from logic on mclk, the clock tree muxes by the gates
//
// How it works
// - interval timer counts on low-speed oscillator
// - standby on sub: only rtc, timer
// - sub select bits enable crystal or input
// - clearing sub stop starts xt1
// - sub select makes subclock the cpu clock
// - sub status shows real cpu source
// - mid enable runs mid oscillator
// - clearing high stop starts high oscillator
// - clearing low select stops low oscillator
// - timer select keeps low oscillator running
// - main select bits enable x1 or input
// - settle code picks x1 settling time
// - clearing main stop starts x1
// - settle status shows cumulative threshold flags
// - clearing sub select returns to main
// - ext select picks x1 as main clock
// - ext status shows x1 really drives
`timescale 1ns/1ps
`default_nettype none
`include "ccsw_defs.vh"

module ccsw_switcher (
   input wire mclk,
   input wire srst,
   input wire ce,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire high_osc_ready_pin,
   input wire mid_osc_ready_pin,
   input wire sub_osc_ready_pin,
   input wire low_osc_ready_pin,
   input wire x1_clk_pin,
   input wire standby_req,
   output reg high_osc_run,
   output reg mid_osc_run,
   output reg low_osc_run,
   output reg main_xtal_en,
   output reg main_ext_in_en,
   output reg main_gain_high,
   output reg sub_xtal_en,
   output reg sub_ext_in_en,
   output reg [1:0] sub_gain,
   output reg itimer_low_osc_sel,
   output reg periph_sub_clk_on,
   output reg [4:0] fclk_gate
);

   localparam ST_IDLE = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_ENGAGE = 2'h2;

   reg [7:0] supply_q;
   reg [7:0] mode_q;
   reg [7:0] run_q;
   reg [7:0] syssel_q;
   reg [7:0] subsel_q;
   reg [7:0] stsel_q;
   reg [7:0] ststat_q;
   reg [7:0] aw_addr_q;
   reg aw_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_held_q;
   reg [4:0] sync1_q;
   reg [4:0] sync2_q;
   reg x1_prev_q;
   reg [`CCSW_CNT_W-1:0] settle_cnt_q;
   reg [1:0] state_q;
   reg [2:0] gap_q;
   reg [2:0] cur_src_q;
   reg [2:0] nxt_src_q;
   reg [2:0] target;
   reg target_ready;
   reg [7:0] flags_d;
   reg [7:0] rd_val;
   reg rd_hit;
   reg wr_hit;
   wire do_write;
   wire x1_rise;
   wire main_ready;
   wire [2:0] flag_idx;

   // two-flop synchronisers for all asynchronous pins
   always @(posedge mclk) begin
      if (srst) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         x1_prev_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= {x1_clk_pin, low_osc_ready_pin, sub_osc_ready_pin,
                     mid_osc_ready_pin, high_osc_ready_pin};
         sync2_q <= sync1_q;
         x1_prev_q <= sync2_q[4];
      end
   end

   assign x1_rise = sync2_q[4] & ~x1_prev_q;

   // axi write channel capture, either order
   assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

   always @(posedge mclk) begin
      if (srst) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CCSW_RESP_OK;
      end else if (ce) begin
         s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CCSW_RESP_OK : `CCSW_RESP_ERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // write address decode
   always @* begin
      case (aw_addr_q & 8'hfc)
         `CCSW_ADDR_SUPPLY, `CCSW_ADDR_MODE, `CCSW_ADDR_RUN, `CCSW_ADDR_SYSSEL,
         `CCSW_ADDR_SUBSEL, `CCSW_ADDR_STSEL, `CCSW_ADDR_STSTAT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // software registers, byte lane 0 only, read-only bits kept
   always @(posedge mclk) begin
      if (srst) begin
         supply_q <= `CCSW_RST_SUPPLY;
         mode_q <= `CCSW_RST_MODE;
         run_q <= `CCSW_RST_RUN;
         syssel_q <= `CCSW_RST_SYSSEL;
         subsel_q <= `CCSW_RST_SUBSEL;
         stsel_q <= `CCSW_RST_STSEL;
      end else if (ce && do_write && w_strb_q[0]) begin
         case (aw_addr_q & 8'hfc)
            `CCSW_ADDR_SUPPLY: supply_q <= w_data_q[7:0] & `CCSW_WM_SUPPLY;
            `CCSW_ADDR_MODE: mode_q <= w_data_q[7:0] & `CCSW_WM_MODE;
            `CCSW_ADDR_RUN: run_q <= w_data_q[7:0] & `CCSW_WM_RUN;
            `CCSW_ADDR_SYSSEL: syssel_q <= w_data_q[7:0] & `CCSW_WM_SYSSEL;
            `CCSW_ADDR_SUBSEL: subsel_q <= w_data_q[7:0] & `CCSW_WM_SUBSEL;
            `CCSW_ADDR_STSEL: stsel_q <= w_data_q[7:0] & `CCSW_WM_STSEL;
            default: supply_q <= supply_q;
         endcase
      end
   end

   // read mux; status bits come from the actual current source
   always @* begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      case (s_axi_araddr & 8'hfc)
         `CCSW_ADDR_SUPPLY: rd_val = supply_q;
         `CCSW_ADDR_MODE: rd_val = mode_q;
         `CCSW_ADDR_RUN: rd_val = run_q;
         `CCSW_ADDR_SYSSEL: begin
            rd_val = syssel_q;
            rd_val[`CCSW_B_SUBSTAT] = (cur_src_q == `CCSW_SRC_SUB) |
                                      (cur_src_q == `CCSW_SRC_LOW);
            rd_val[`CCSW_B_EXTSTAT] = (cur_src_q == `CCSW_SRC_MAIN);
            rd_val[`CCSW_B_MIDSTAT] = (cur_src_q == `CCSW_SRC_MID);
         end
         `CCSW_ADDR_SUBSEL: rd_val = subsel_q;
         `CCSW_ADDR_STSEL: rd_val = stsel_q;
         `CCSW_ADDR_STSTAT: rd_val = ststat_q;
         default: rd_hit = 1'b0;
      endcase
   end

   // axi read channel
   always @(posedge mclk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CCSW_RESP_OK;
      end else if (ce) begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? `CCSW_RESP_OK : `CCSW_RESP_ERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         settle_cnt_q <= {`CCSW_CNT_W{1'b0}};
      end else if (ce) begin
         if (run_q[`CCSW_B_MAIN_OSC_STOP] | ~mode_q[`CCSW_B_MAINOSC]) begin
            settle_cnt_q <= {`CCSW_CNT_W{1'b0}};
         end else if (x1_rise && settle_cnt_q != `CCSW_CNT_MAX) begin
            settle_cnt_q <= settle_cnt_q + 1'b1;
         end
      end
   end

   always @* begin
      flags_d[7] = settle_cnt_q[18:8] != 11'h000;
      flags_d[6] = settle_cnt_q[18:9] != 10'h000;
      flags_d[5] = settle_cnt_q[18:10] != 9'h000;
      flags_d[4] = settle_cnt_q[18:11] != 8'h00;
      flags_d[3] = settle_cnt_q[18:13] != 6'h00;
      flags_d[2] = settle_cnt_q[18:15] != 4'h0;
      flags_d[1] = settle_cnt_q[18:17] != 2'h0;
      flags_d[0] = settle_cnt_q[18];
   end

   always @(posedge mclk) begin
      if (srst) begin
         ststat_q <= 8'h00;
      end else if (ce) begin
         ststat_q <= flags_d;
      end
   end

   assign flag_idx = `CCSW_FLAG_TOP - stsel_q[2:0];
   // external main needs no settle wait
   assign main_ready = ~run_q[`CCSW_B_MAIN_OSC_STOP] & mode_q[`CCSW_B_MAINOSC] &
                       (mode_q[`CCSW_B_MAINEXT] | ststat_q[flag_idx]);

   // requested source and whether it is ready to take over
   always @* begin
      target = `CCSW_SRC_HIGH;
      target_ready = 1'b0;
      if (syssel_q[`CCSW_B_SUBSEL]) begin
         if (subsel_q[`CCSW_B_LOWSEL]) begin
            target = `CCSW_SRC_LOW;
            target_ready = low_osc_run & sync2_q[3];
         end else begin
            target = `CCSW_SRC_SUB;
            target_ready = ~run_q[`CCSW_B_SSTOP] & mode_q[`CCSW_B_SUBOSC] &
                           (mode_q[`CCSW_B_SUBEXT] | sync2_q[2]);
         end
      // cleared sub select returns to main
      end else if (syssel_q[`CCSW_B_EXTSEL]) begin
         target = `CCSW_SRC_MAIN;
         target_ready = main_ready;
      end else if (syssel_q[`CCSW_B_MIDSEL]) begin
         target = `CCSW_SRC_MID;
         target_ready = run_q[`CCSW_B_MIDEN] & sync2_q[1];
      end else begin
         target = `CCSW_SRC_HIGH;
         target_ready = ~run_q[`CCSW_B_HSTOP] & sync2_q[0];
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         gap_q <= 3'h0;
         cur_src_q <= `CCSW_SRC_HIGH;
         nxt_src_q <= `CCSW_SRC_HIGH;
         fclk_gate <= 5'h01;
      end else if (ce) begin
         case (state_q)
            ST_IDLE: begin
               if (target != cur_src_q && target_ready) begin
                  nxt_src_q <= target;
                  fclk_gate <= 5'h00;
                  gap_q <= `CCSW_GAP_CYC;
                  state_q <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (gap_q == 3'h1) begin
                  fclk_gate <= 5'h01 << nxt_src_q;
                  gap_q <= `CCSW_GAP_CYC;
                  state_q <= ST_ENGAGE;
               end else begin
                  gap_q <= gap_q - 3'h1;
               end
            end
            ST_ENGAGE: begin
               if (gap_q == 3'h1) begin
                  cur_src_q <= nxt_src_q;
                  state_q <= ST_IDLE;
               end else begin
                  gap_q <= gap_q - 3'h1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // oscillator run and mode outputs; the live source is kept running, except x1, which main stop turns off even while live
   always @(posedge mclk) begin
      if (srst) begin
         high_osc_run <= 1'b1;
         mid_osc_run <= 1'b0;
         low_osc_run <= 1'b0;
         main_xtal_en <= 1'b0;
         main_ext_in_en <= 1'b0;
         main_gain_high <= 1'b0;
         sub_xtal_en <= 1'b0;
         sub_ext_in_en <= 1'b0;
         sub_gain <= 2'h0;
         itimer_low_osc_sel <= 1'b0;
         periph_sub_clk_on <= 1'b1;
      end else if (ce) begin
         // high stop clear runs high oscillator
         high_osc_run <= ~run_q[`CCSW_B_HSTOP] | (cur_src_q == `CCSW_SRC_HIGH);
         mid_osc_run <= run_q[`CCSW_B_MIDEN] | (cur_src_q == `CCSW_SRC_MID);
         low_osc_run <= subsel_q[`CCSW_B_LOWSEL] | supply_q[`CCSW_B_ITSEL] |
                        (cur_src_q == `CCSW_SRC_LOW);
         main_xtal_en <= mode_q[`CCSW_B_MAINOSC] & ~mode_q[`CCSW_B_MAINEXT] &
                         ~run_q[`CCSW_B_MAIN_OSC_STOP];
         main_ext_in_en <= mode_q[`CCSW_B_MAINOSC] & mode_q[`CCSW_B_MAINEXT] &
                           ~run_q[`CCSW_B_MAIN_OSC_STOP];
         main_gain_high <= mode_q[`CCSW_B_GAIN];
         // sub crystal or input; sub stop
         sub_xtal_en <= mode_q[`CCSW_B_SUBOSC] & ~mode_q[`CCSW_B_SUBEXT] &
                        (~run_q[`CCSW_B_SSTOP] | (cur_src_q == `CCSW_SRC_SUB));
         sub_ext_in_en <= mode_q[`CCSW_B_SUBOSC] & mode_q[`CCSW_B_SUBEXT] &
                          (~run_q[`CCSW_B_SSTOP] | (cur_src_q == `CCSW_SRC_SUB));
         sub_gain <= mode_q[2:1];
         itimer_low_osc_sel <= supply_q[`CCSW_B_ITSEL];
         periph_sub_clk_on <= ~(supply_q[`CCSW_B_LOWPWR] & standby_req &
                                (cur_src_q == `CCSW_SRC_SUB));
      end
   end

endmodule // ccsw_switcher
`default_nettype wire

// ### dv/ccsw_checker.sv
// checker for the clock source switcher: gating, run outputs, bus timing
// assumes binding to ccsw_switcher, one clock domain on mclk
`timescale 1ns/1ps
`default_nettype none
module ccsw_checker (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic standby_req,
   input wire logic high_osc_run,
   input wire logic mid_osc_run,
   input wire logic low_osc_run,
   input wire logic periph_sub_clk_on,
   input wire logic [4:0] fclk_gate
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // old gate has just dropped
   sequence s_gap_open;
      fclk_gate == 5'h00 && $past(fclk_gate) != 5'h00;
   endsequence
   // quiet gap, then the new gate within a bounded wait
   sequence s_gap_close;
      (fclk_gate == 5'h00) [*3] ##[1:6] (fclk_gate != 5'h00);
   endsequence
   AST_GATE_ONEHOT: assert property ($onehot0(fclk_gate))
      else $error("two clock gates open");
   AST_NO_DIRECT_SWAP: assert property ((fclk_gate != 5'h00 && $past(fclk_gate) != 5'h00)
      |-> fclk_gate == $past(fclk_gate)) else $error("gate swapped without gap");
   AST_GAP_HOLD: assert property (s_gap_open |-> s_gap_close)
      else $error("switch gap wrong");
   AST_RESET_STATE: assert property ($past(srst)
      |-> fclk_gate == 5'h01 && high_osc_run && periph_sub_clk_on) else $error("reset state");
   AST_HIGH_KEPT: assert property (fclk_gate[0] |-> high_osc_run)
      else $error("high osc stopped while used");
   AST_MID_KEPT: assert property (fclk_gate[1] |-> mid_osc_run)
      else $error("mid osc stopped while used");
   AST_LOW_KEPT: assert property (fclk_gate[4] |-> low_osc_run)
      else $error("low osc stopped while used");
   AST_STANDBY_FEED: assert property (!standby_req && !$past(standby_req)
      |-> periph_sub_clk_on) else $error("sub feed off outside standby");
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
      else $error("read answer late");
   AST_CE_FREEZE: assert property (!ce |=> $stable(fclk_gate) && $stable(s_axi_rvalid))
      else $error("state moved with ce low");
endmodule // ccsw_checker
bind ccsw_switcher ccsw_checker ccsw_checker_inst (.*);
`default_nettype wire

// ### dv/ccsw_switcher_tb.sv
// testbench for the clock source switcher: registers, source switches, settle flags
// assumes ccsw_switcher, its defines and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "ccsw_defs.vh"
module ccsw_switcher_tb;
   logic mclk, srst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, high_osc_ready_pin, mid_osc_ready_pin, sub_osc_ready_pin;
   logic low_osc_ready_pin, standby_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr, v;
   logic [31:0] s_axi_wdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] x1_ph = 2'h0;
   wire x1_clk_pin = x1_ph[1];
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, sub_gain;
   wire [31:0] s_axi_rdata;
   wire high_osc_run, mid_osc_run, low_osc_run, main_xtal_en, main_ext_in_en;
   wire main_gain_high, sub_xtal_en, sub_ext_in_en, itimer_low_osc_sel, periph_sub_clk_on;
   wire [4:0] fclk_gate;
   int failures, checks_done, seed;
   localparam logic [7:0] a_sup = `CCSW_ADDR_SUPPLY;
   localparam logic [7:0] a_mode = `CCSW_ADDR_MODE;
   localparam logic [7:0] a_run = `CCSW_ADDR_RUN;
   localparam logic [7:0] a_sys = `CCSW_ADDR_SYSSEL;
   localparam logic [7:0] a_sub = `CCSW_ADDR_SUBSEL;
   localparam logic [7:0] a_sts = `CCSW_ADDR_STSTAT;
   logic [7:0] rst_tab [7] = '{`CCSW_RST_SUPPLY, `CCSW_RST_MODE, `CCSW_RST_RUN,
      `CCSW_RST_SYSSEL, `CCSW_RST_SUBSEL, `CCSW_RST_STSEL, 8'h00};
   logic [7:0] rw_adr [4] = '{a_sup, a_mode, a_sub, `CCSW_ADDR_STSEL};
   logic [7:0] rw_msk [4] = '{`CCSW_WM_SUPPLY, `CCSW_WM_MODE, `CCSW_WM_SUBSEL, `CCSW_WM_STSEL};

   ccsw_switcher ccsw_switcher_inst (.*);

   // clock and a free running x1 clock at a quarter rate
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) x1_ph <= x1_ph + 2'h1;

   task automatic test_done;
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // settle flags expected when the coded threshold is first reached
   function automatic logic [7:0] exp_flags(input logic [2:0] code);
      return ~(8'hff >> (4'(code) + 4'h1));
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic give_up;
      failures++;
      test_done();
   endtask

   // one write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, x};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
         end
      end while (n < 40 && (s_axi_awvalid || s_axi_wvalid || s_axi_bready));
      if (n >= 40) give_up();
   endtask

   // one read, data kept in d
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            chk({30'h0, s_axi_rresp}, {30'h0, er});
         end
      end while (n < 40 && (s_axi_arvalid || s_axi_rready));
      if (n >= 40) give_up();
   endtask

   // read until the masked bits reach the wanted value
   task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] w);
      int k;
      k = 0;
      do begin
         rd(a, `CCSW_RESP_OK);
         k++;
      end while (k < 3000 && (d[7:0] & m) != w);
      if (k >= 3000) give_up();
   endtask

   initial begin
      seed = 10336;
      failures = 0;
      checks_done = 0;
      {srst, ce} = 2'b11;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h1;
      {high_osc_ready_pin, mid_osc_ready_pin, low_osc_ready_pin} = 3'h7;
      {sub_osc_ready_pin, standby_req} = 2'h0;
      cyc(10);
      srst <= 1'b0;
      cyc(2);
      // reset values, bits above byte zero read zero
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), `CCSW_RESP_OK);
         chk(d, {24'h0, rst_tab[i]});
      end
      rd(8'h1c, `CCSW_RESP_ERR);
      chk(d, 32'h0);
      wr(8'h1c, 8'hff, `CCSW_RESP_ERR);
      wr(a_sts, 8'hff, `CCSW_RESP_OK);
      rd(a_sts, `CCSW_RESP_OK);
      chk(d, 32'h0);
      // random values through the plain registers, then back to zero
      for (int i = 0; i < 32; i++) begin
         v = 8'($random(seed));
         wr(rw_adr[i % 4], v, `CCSW_RESP_OK);
         rd(rw_adr[i % 4], `CCSW_RESP_OK);
         chk(d, {24'h0, v & rw_msk[i % 4]});
         if (i % 4 == 1) chk(32'(sub_gain), 32'(v[2:1]));
      end
      for (int i = 0; i < 4; i++) wr(rw_adr[i], 8'h00, `CCSW_RESP_OK);
      // high to mid: start, settle, select, confirm, stop old
      wr(a_run, 8'hc2, `CCSW_RESP_OK);
      cyc(2);
      chk(32'(mid_osc_run), 32'h1);
      cyc(800);
      wr(a_sys, 8'h01, `CCSW_RESP_OK);
      poll(a_sys, 8'h02, 8'h02);
      chk(32'(fclk_gate), 32'h02);
      wr(a_run, 8'hc3, `CCSW_RESP_OK);
      cyc(2);
      chk(32'(high_osc_run), 32'h0);
      // mid to sub crystal, selected before the crystal is ready
      wr(a_sup, 8'h90, `CCSW_RESP_OK);
      wr(a_mode, 8'h10, `CCSW_RESP_OK);
      wr(a_run, 8'h83, `CCSW_RESP_OK);
      cyc(2);
      chk(32'({itimer_low_osc_sel, low_osc_run, sub_xtal_en, sub_ext_in_en}), 32'he);
      wr(a_sys, 8'h41, `CCSW_RESP_OK);
      cyc(30);
      rd(a_sys, `CCSW_RESP_OK);
      chk(d, 32'h43);
      cyc(50 + ($random(seed) & 63));
      sub_osc_ready_pin <= 1'b1;
      poll(a_sys, 8'h80, 8'h80);
      chk(32'(fclk_gate), 32'h08);
      standby_req <= 1'b1;
      cyc(4);
      chk(32'(periph_sub_clk_on), 32'h0);
      standby_req <= 1'b0;
      cyc(4);
      chk(32'(periph_sub_clk_on), 32'h1);
      wr(a_run, 8'h81, `CCSW_RESP_OK);
      cyc(2);
      chk(32'(mid_osc_run), 32'h0);
      // sub back to high, then a frozen stretch with ce low
      wr(a_run, 8'h80, `CCSW_RESP_OK);
      cyc(13000);
      wr(a_sys, 8'h00, `CCSW_RESP_OK);
      poll(a_sys, 8'h80, 8'h00);
      chk(32'(fclk_gate), 32'h01);
      wr(a_run, 8'hc0, `CCSW_RESP_OK);
      ce <= 1'b0;
      cyc(5);
      ce <= 1'b1;
      // high to x1 crystal through the settle flags
      wr(a_mode, 8'h41, `CCSW_RESP_OK);
      wr(`CCSW_ADDR_STSEL, 8'h02, `CCSW_RESP_OK);
      wr(a_run, 8'h40, `CCSW_RESP_OK);
      cyc(2);
      chk(32'({main_xtal_en, main_ext_in_en, main_gain_high}), 32'h5);
      poll(a_sts, 8'h20, 8'h20);
      chk(d, {24'h0, exp_flags(3'h2)});
      wr(a_sys, 8'h10, `CCSW_RESP_OK);
      poll(a_sys, 8'h20, 8'h20);
      chk(32'(fclk_gate), 32'h04);
      wr(a_run, 8'h01, `CCSW_RESP_OK);
      wr(a_mode, 8'hf1, `CCSW_RESP_OK);
      cyc(2);
      chk(32'({high_osc_run, main_ext_in_en, sub_ext_in_en}), 32'h3);
      // x1 to low osc and back, then low osc released
      wr(a_sub, 8'h01, `CCSW_RESP_OK);
      wr(a_sys, 8'h50, `CCSW_RESP_OK);
      poll(a_sys, 8'h80, 8'h80);
      chk(32'(fclk_gate), 32'h10);
      wr(a_sys, 8'h10, `CCSW_RESP_OK);
      poll(a_sys, 8'h80, 8'h00);
      wr(a_sub, 8'h00, `CCSW_RESP_OK);
      cyc(2);
      chk(32'(low_osc_run), 32'h1);
      wr(a_sup, 8'h00, `CCSW_RESP_OK);
      cyc(2);
      chk(32'(low_osc_run), 32'h0);
      test_done();
   end
endmodule // ccsw_switcher_tb
`default_nettype wire
